// [src/asr_readout.sv]
// conversion control and serial readout for a 12-bit converter, two modes
// How it works
// - internal mode: convert-start falling edge starts conversion and holds the input.
// - internal mode: result is due in the output register within 3.3 us; it lands about 3.36 us after the pin falls, once no read is under way.
// - after the sixteenth clock data goes high-z; in internal mode the shift register also resets.
// - convert-start falling edge resets the output shift register; in internal mode only while serial clock is low.
// - internal mode: bits shift on falling edges; first zero follows first rise.
// - word is four zeros then twelve result bits, msb first.
// - lsb leaves on fifteenth fall, stays valid to sixteenth, then high-z.
// - internal mode: clocks past sixteen restart the shift and drive the data line again.
// - internal mode: edge counter clears on convert-start fall only while serial clock is low.
// - the sixteen read clocks may come in separate bursts.
// - serial mode: select falling holds input, drives data, starts conversion.
// - serial mode: track resumes on the fourteenth falling edge.
// - serial mode: early select rise aborts; else high-z at sixteenth fall.
// - serial mode: select fall shows first zero; each fall shifts next bit.
// - rising-edge hosts take first zero on first rise; lsb at sixteenth rise.
// - power-up in internal mode; stay there without clocks during conversion.
// - serial clock edge during conversion with convert-start low enters serial mode.
// - select low then high without clock edges returns to internal mode.
// - clock edges during select low keep serial mode; count decides power-down.
// - select rise after fourth, before eleventh fall powers the device down.
// - dummy conversion past eleventh fall powers up, fully after sixteen clocks.
// - result is two's complement, one lsb is full scale over 4096.
`timescale 1ns/1ps
`include "asr_params.svh"

module asr_readout
	import asr_pkg::*;
#(
	parameter int CONV_CYCLES = `ASR_CONVERSION_INTERVAL_NS / `ASR_CLK_PERIOD_NS,
	parameter int FIFO_DEPTH  = `ASR_FIFO_DEPTH
) (
	input  wire logic                        ref_clk,
	input  wire logic                        reset_n,
	input  wire logic                        serial_clock,
	input  wire logic                        convert_start_n,
	input  wire logic [`ASR_RESULT_BITS-1:0] sar_code,
	output logic                             serial_data_out,
	output logic                             serial_data_oe,
	output logic                             track_hold,
	output logic                             power_down,
	output logic                             serial_mode,
	output logic                             conversion_busy
);

	localparam int TW = $clog2(CONV_CYCLES + 1);

	// ==========================================
	// declarations
	logic                        sclk_meta;
	logic                        sclk_sync;
	logic                        sclk_prev;
	logic                        start_meta;
	logic                        start_sync;
	logic                        start_prev;
	logic                        sclk_rise;
	logic                        sclk_fall;
	logic                        sclk_edge;
	logic                        start_fall;
	logic                        start_rise;
	asr_mode_t                   mode;
	asr_conv_t                   conv_state;
	logic [TW-1:0]               conv_timer;
	logic [`ASR_RESULT_BITS-1:0] sample_code;
	logic [`ASR_COUNT_BITS-1:0]  bit_count;
	logic [`ASR_COUNT_BITS-1:0]  next_count;
	asr_word_t                   output_word;
	asr_word_t                   serial_word;
	logic                        frame_active;
	logic                        frame_edge_seen;
	logic                        dummy_frame;
	logic                        mode_switch;
	logic                        fifo_in_valid;
	logic                        fifo_in_ready;
	asr_word_t                   fifo_in_word;
	asr_word_t                   fifo_out_word;
	logic                        fifo_out_valid;
	logic                        fifo_out_ready;

	// ==========================================
	// bit picker: position 0 is the first leading zero
	function automatic logic asr_bit(input asr_word_t word, input logic [4:0] idx);
		logic [3:0] pos;
		pos = 4'hF - idx[3:0];
		return word[pos];
	endfunction : asr_bit

	// ==========================================
	// pin synchronisers and edge finders
	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			sclk_meta  <= 1'b0;
			sclk_sync  <= 1'b0;
			sclk_prev  <= 1'b0;
			start_meta <= 1'b1;
			start_sync <= 1'b1;
			start_prev <= 1'b1;
		end
		else
		begin
			sclk_meta  <= serial_clock;
			sclk_sync  <= sclk_meta;
			sclk_prev  <= sclk_sync;
			start_meta <= convert_start_n;
			start_sync <= start_meta;
			start_prev <= start_sync;
		end
	end

	assign sclk_rise  = sclk_sync && !sclk_prev;
	assign sclk_fall  = !sclk_sync && sclk_prev;
	assign sclk_edge  = sclk_rise || sclk_fall;
	assign start_fall = !start_sync && start_prev;
	assign start_rise = start_sync && !start_prev;

	// any clock edge while converting with the start pin low
	assign mode_switch = (mode == ASR_MODE_INTERNAL) && (conv_state == ASR_CONV_BUSY)
		&& !start_sync && sclk_edge;

	// ==========================================
	// operating mode
	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			mode <= ASR_MODE_INTERNAL;
		end
		else if (mode_switch)
		begin
			mode <= ASR_MODE_SERIAL;
		end
		else if (mode == ASR_MODE_SERIAL && frame_active && start_rise && !frame_edge_seen
			&& !sclk_edge)
		begin
			mode <= ASR_MODE_INTERNAL;
		end
	end

	assign serial_mode = (mode == ASR_MODE_SERIAL);

	// ==========================================
	// input sample taken at the hold instant
	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			sample_code <= '0;
		end
		else if (start_fall)
		begin
			sample_code <= sar_code;
		end
	end

	// ==========================================
	// internal-clock conversion; a full buffer stalls the finish
	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			conv_state <= ASR_CONV_IDLE;
			conv_timer <= '0;
		end
		else if (mode_switch)
		begin
			conv_state <= ASR_CONV_IDLE;
		end
		else if (mode == ASR_MODE_INTERNAL && start_fall)
		begin
			conv_state <= ASR_CONV_BUSY;
			conv_timer <= '0;
		end
		else
		begin
			unique case (conv_state)
				ASR_CONV_IDLE:
				begin
					conv_timer <= '0;
				end
				ASR_CONV_BUSY:
				begin
					if (conv_timer == TW'(CONV_CYCLES - 1))
					begin
						conv_state <= ASR_CONV_DONE;
					end
					else
					begin
						conv_timer <= conv_timer + 1'b1;
					end
				end
				ASR_CONV_DONE:
				begin
					if (fifo_in_ready)
					begin
						conv_state <= ASR_CONV_IDLE;
					end
				end
				default:
				begin
					conv_state <= ASR_CONV_IDLE;
				end
			endcase
		end
	end

	assign conversion_busy = (conv_state != ASR_CONV_IDLE) || frame_active;

	// result is already two's complement from the comparator array
	assign fifo_in_valid     = (conv_state == ASR_CONV_DONE);
	assign fifo_in_word.lead = `ASR_LEAD_VALUE;
	assign fifo_in_word.code = sample_code;

	// ==========================================
	// result buffer; only drained while no read is under way
	assign fifo_out_ready = (mode == ASR_MODE_INTERNAL) && !serial_data_oe
		&& (bit_count == '0);

	asr_fifo #(
		.WIDTH (`ASR_WORD_BITS),
		.DEPTH (FIFO_DEPTH)
	) u_result_fifo (
		.ref_clk   (ref_clk),
		.reset_n   (reset_n),
		.in_data   (fifo_in_word),
		.in_valid  (fifo_in_valid),
		.in_ready  (fifo_in_ready),
		.out_data  (fifo_out_word),
		.out_valid (fifo_out_valid),
		.out_ready (fifo_out_ready)
	);

	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			output_word <= '0;
		end
		else if (fifo_out_valid && fifo_out_ready)
		begin
			output_word <= fifo_out_word;
		end
	end

	assign serial_word.lead = `ASR_LEAD_VALUE;
	assign serial_word.code = sample_code;

	// ==========================================
	// serial-mode frame bookkeeping
	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			frame_active    <= 1'b0;
			frame_edge_seen <= 1'b0;
			dummy_frame     <= 1'b0;
		end
		else if (mode == ASR_MODE_SERIAL)
		begin
			if (start_fall)
			begin
				frame_active    <= 1'b1;
				frame_edge_seen <= 1'b0;
				dummy_frame     <= power_down;
			end
			else if (frame_active && start_rise)
			begin
				frame_active <= 1'b0;
			end
			else if (frame_active && sclk_fall && next_count == `ASR_LAST_EDGE)
			begin
				frame_active <= 1'b0;
			end
			if (frame_active && sclk_edge)
			begin
				frame_edge_seen <= 1'b1;
			end
		end
		else
		begin
			frame_active    <= 1'b0;
			frame_edge_seen <= 1'b0;
			dummy_frame     <= 1'b0;
		end
	end

	// ==========================================
	// power-down, serial mode only
	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			power_down <= 1'b0;
		end
		else if (mode == ASR_MODE_SERIAL && frame_active)
		begin
			if (start_rise && frame_edge_seen && !power_down && bit_count >= `ASR_PD_FIRST
				&& bit_count < `ASR_PD_LAST)
			begin
				power_down <= 1'b1;
			end
			else if (sclk_fall && power_down && next_count == `ASR_PD_LAST)
			begin
				power_down <= 1'b0;
			end
		end
	end

	// ==========================================
	// track/hold: high while holding
	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			track_hold <= 1'b0;
		end
		else if (start_fall)
		begin
			track_hold <= 1'b1;
		end
		else if (mode_switch || conv_state == ASR_CONV_DONE)
		begin
			track_hold <= 1'b0;
		end
		else if (mode == ASR_MODE_SERIAL && frame_active)
		begin
			if (start_rise || (sclk_fall && next_count == `ASR_TRACK_EDGE))
			begin
				track_hold <= 1'b0;
			end
		end
	end

	// ==========================================
	// shift register and data pin; count survives gaps between bursts
	assign next_count = bit_count + 1'b1;

	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			bit_count       <= '0;
			serial_data_out <= 1'b0;
			serial_data_oe  <= 1'b0;
		end
		else if (mode_switch)
		begin
			// an aborted conversion must not leave the line driven in a frameless mode
			serial_data_oe  <= 1'b0;
			serial_data_out <= 1'b0;
		end
		else if (mode == ASR_MODE_INTERNAL)
		begin
			if (start_fall)
			begin
				serial_data_oe  <= 1'b0;
				serial_data_out <= 1'b0;
				if (!sclk_sync)
				begin
					bit_count <= '0;
				end
			end
			else if (sclk_rise && bit_count == '0)
			begin
				serial_data_oe  <= 1'b1;
				serial_data_out <= asr_bit(output_word, 5'h00);
			end
			else if (sclk_fall && serial_data_oe)
			begin
				if (next_count == `ASR_LAST_EDGE)
				begin
					bit_count       <= '0;
					serial_data_oe  <= 1'b0;
					serial_data_out <= 1'b0;
				end
				else
				begin
					bit_count       <= next_count;
					serial_data_out <= asr_bit(output_word, next_count);
				end
			end
		end
		else
		begin
			if (start_fall)
			begin
				bit_count       <= '0;
				serial_data_oe  <= 1'b1;
				serial_data_out <= asr_bit(serial_word, 5'h00);
			end
			else if (frame_active && start_rise)
			begin
				serial_data_oe  <= 1'b0;
				serial_data_out <= 1'b0;
			end
			else if (frame_active && sclk_fall)
			begin
				bit_count <= next_count;
				if (next_count == `ASR_LAST_EDGE)
				begin
					serial_data_oe  <= 1'b0;
					serial_data_out <= 1'b0;
				end
				else
				begin
					// a dummy frame drives nothing useful but keeps the timing
					serial_data_out <= dummy_frame ? 1'b0 : asr_bit(serial_word, next_count);
				end
			end
		end
	end

endmodule : asr_readout

// [src/asr_params.svh]
// constants for the converter readout: timing, bit positions and fifo sizing
`ifndef ASR_PARAMS_SVH
`define ASR_PARAMS_SVH

// ==========================================
// clock and conversion timing
`define ASR_CLK_PERIOD_NS          10
`define ASR_CONVERSION_INTERVAL_NS 3300

// ==========================================
// word layout
`define ASR_RESULT_BITS 12
`define ASR_LEAD_BITS   4
`define ASR_WORD_BITS   16
`define ASR_LEAD_VALUE  4'h0

// ==========================================
// serial clock edge counts
`define ASR_COUNT_BITS  5
`define ASR_LAST_EDGE   5'h10
`define ASR_TRACK_EDGE  5'h0E
`define ASR_PD_FIRST    5'h04
`define ASR_PD_LAST     5'h0B

// ==========================================
// result buffer
`define ASR_FIFO_DEPTH  16

`endif

// [src/asr_pkg.sv]
// types used by the converter readout; its result buffer takes plain WIDTH-bit words
`include "asr_params.svh"

package asr_pkg;

	// ==========================================
	// operating modes
	typedef enum logic
	{
		ASR_MODE_INTERNAL = 1'b0,
		ASR_MODE_SERIAL   = 1'b1
	} asr_mode_t;

	// ==========================================
	// internal-clock conversion sequencer
	typedef enum logic [1:0]
	{
		ASR_CONV_IDLE = 2'b00,
		ASR_CONV_BUSY = 2'b01,
		ASR_CONV_DONE = 2'b10
	} asr_conv_t;

	// ==========================================
	// serial word: leading zeros then two's complement result
	typedef struct packed
	{
		logic [`ASR_LEAD_BITS-1:0]   lead;
		logic [`ASR_RESULT_BITS-1:0] code;
	} asr_word_t;

endpackage : asr_pkg

// [src/asr_fifo.sv]
// result buffer: registered read data, valid/ready on both sides
`timescale 1ns/1ps

module asr_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 16
) (
	input  wire logic             ref_clk,
	input  wire logic             reset_n,
	input  wire logic [WIDTH-1:0] in_data,
	input  wire logic             in_valid,
	output logic                  in_ready,
	output logic      [WIDTH-1:0] out_data,
	output logic                  out_valid,
	input  wire logic             out_ready
);

	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr;
	logic [AW-1:0]    rd_ptr;
	logic [AW:0]      fill;
	logic             push;
	logic             pop;

	// ==========================================
	// handshakes
	assign in_ready = (fill != (AW+1)'(DEPTH));
	assign push     = in_valid && in_ready;
	assign pop      = (fill != '0) && (!out_valid || out_ready);

	// ==========================================
	// storage
	always_ff @(posedge ref_clk)
	begin
		if (push)
		begin
			mem[wr_ptr] <= in_data;
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			fill   <= '0;
		end
		else
		begin
			if (push)
			begin
				wr_ptr <= wr_ptr + 1'b1;
			end
			if (pop)
			begin
				rd_ptr <= rd_ptr + 1'b1;
			end
			fill <= fill + (AW+1)'(push) - (AW+1)'(pop);
		end
	end

	// ==========================================
	// registered read stage
	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			out_data  <= '0;
			out_valid <= 1'b0;
		end
		else if (pop)
		begin
			out_data  <= mem[rd_ptr];
			out_valid <= 1'b1;
		end
		else if (out_ready)
		begin
			out_valid <= 1'b0;
		end
	end

endmodule : asr_fifo

// [verification/asr_readout_asserts.sv]
// port-level checks on the converter readout
`timescale 1ns/1ps

module asr_readout_asserts #(
	parameter int CONV_CYCLES = 330
) (
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic serial_clock,
	input wire logic convert_start_n,
	input wire logic serial_data_out,
	input wire logic serial_data_oe,
	input wire logic track_hold,
	input wire logic power_down,
	input wire logic serial_mode,
	input wire logic conversion_busy
);
	// pins pass a two-flop sync, so answers land a few cycles late
	localparam int CONV_MAX = CONV_CYCLES + 1;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!reset_n);

	// ======
	// internal-clock mode
	hold_on_start_a: assert property (
		!serial_mode && !serial_clock && $fell(convert_start_n) |-> ##[2:5] track_hold)
		else $error("hold not taken at start");
	conv_bound_a: assert property (
		$rose(track_hold) && !serial_mode |-> ##[1:CONV_MAX] !track_hold)
		else $error("conversion overran");
	start_clears_a: assert property (
		!serial_mode && !serial_clock && $fell(convert_start_n) |-> ##[2:5] !serial_data_oe)
		else $error("shift register not reset");
	first_zero_a: assert property (
		!serial_mode && !conversion_busy && !serial_data_oe && $rose(serial_clock)
		|-> ##[2:5] serial_data_oe && !serial_data_out)
		else $error("first zero missing");

	// ======
	// serial-clock mode and mode change
	frame_open_a: assert property (
		serial_mode && !power_down && $fell(convert_start_n)
		|-> ##[2:5] serial_data_oe && track_hold && !serial_data_out)
		else $error("frame did not open");
	select_abort_a: assert property (
		serial_mode && $rose(convert_start_n) |-> ##[2:5] !serial_data_oe)
		else $error("line still driven");
	mode_switch_a: assert property (
		!serial_mode && conversion_busy && !convert_start_n && $changed(serial_clock)
		|-> ##[2:5] serial_mode)
		else $error("no switch to serial mode");
	mode_cause_a: assert property (
		$rose(serial_mode) |-> $past(conversion_busy, 2))
		else $error("mode left without cause");
	pd_serial_a: assert property (
		power_down |-> serial_mode)
		else $error("power-down in internal mode");

	cover property (!serial_mode && $fell(serial_data_oe));
	cover property ($rose(serial_mode));
	cover property ($rose(power_down));
endmodule : asr_readout_asserts

// [verification/asr_host_model.sv]
// host serial master: drives clock and start pin, shifts in the data line
`timescale 1ns/1ps

module asr_host_model #(
	parameter int QUIET_CYCLES = 4
) (
	input  wire logic ref_clk,
	input  wire logic serial_data_out,
	input  wire logic serial_data_oe,
	output logic      serial_clock,
	output logic      convert_start_n
);
	logic        line;
	logic [15:0] got;

	// released line shows the inverse, so a stale bit never reads as good
	assign line = serial_data_oe ? serial_data_out : ~serial_data_out;

	initial
	begin
		serial_clock = 1'b0;
		convert_start_n = 1'b1;
		got = 16'h0000;
	end

	// ======
	// host actions
	task automatic wait_cyc(input int n);
		repeat (n) @(posedge ref_clk);
	endtask : wait_cyc

	// a fall only comes after a quiet gap of QUIET_CYCLES reference clock cycles
	task automatic pin(input logic v);
		if (!v)
			wait_cyc(QUIET_CYCLES);
		@(posedge ref_clk) convert_start_n <= v;
	endtask : pin

	// 80 ns period, bit taken just before each fall, clock parked low after
	task automatic clk(input int n);
		repeat (n)
		begin
			@(posedge ref_clk) serial_clock <= 1'b1;
			wait_cyc(4);
			got = {got[14:0], line};
			serial_clock <= 1'b0;
			wait_cyc(3);
		end
	endtask : clk
endmodule : asr_host_model

// [verification/asr_readout_test.sv]
// testbench for the converter readout: both modes, power-down, mode return
`timescale 1ns/1ps
`include "asr_params.svh"

module asr_readout_test
	import asr_pkg::*;
;
	logic        ref_clk;
	logic        reset_n;
	logic        serial_clock;
	logic        convert_start_n;
	logic [11:0] sar_code;
	logic        serial_data_out;
	logic        serial_data_oe;
	logic        track_hold;
	logic        power_down;
	logic        serial_mode;
	logic        conversion_busy;
	int          miscompares;
	int          checks_done;

	initial ref_clk = 1'b0;
	always #5 ref_clk = ~ref_clk;

	asr_readout u_dut (
		.ref_clk(ref_clk), .reset_n(reset_n), .serial_clock(serial_clock),
		.convert_start_n(convert_start_n), .sar_code(sar_code),
		.serial_data_out(serial_data_out), .serial_data_oe(serial_data_oe),
		.track_hold(track_hold), .power_down(power_down),
		.serial_mode(serial_mode), .conversion_busy(conversion_busy));

	asr_host_model u_host (
		.ref_clk(ref_clk), .serial_data_out(serial_data_out),
		.serial_data_oe(serial_data_oe), .serial_clock(serial_clock),
		.convert_start_n(convert_start_n));

	// ======
	// shared helpers
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	// host actions routed through one place each
	task automatic start_pin(input logic level);
		u_host.pin(level);
	endtask : start_pin

	task automatic idle(input int n);
		u_host.wait_cyc(n);
	endtask : idle

	task automatic pulses(input int n);
		u_host.clk(n);
	endtask : pulses

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : wrap_up

	// ======
	// scenarios
	task automatic read_int(input logic [11:0] code, input logic split);
		@(posedge ref_clk) sar_code <= code;
		start_pin(1'b0);
		idle(10);
		check(track_hold, 1'b1);
		start_pin(1'b1);
		idle(340);
		check(track_hold, 1'b0);
		if (split)
		begin
			pulses(8);
			idle(30);
			pulses(8);
		end
		else
			pulses(16);
		check(u_host.got, {`ASR_LEAD_VALUE, code});
		idle(4);
		check(serial_data_oe, 1'b0);
	endtask : read_int

	task automatic extra_clocks();
		read_int(12'h801, 1'b0);
		pulses(1);
		idle(6);
		check(serial_data_oe, 1'b1);
		@(posedge ref_clk) sar_code <= 12'h3C6;
		start_pin(1'b0);
		idle(6);
		check(serial_data_oe, 1'b0);
		start_pin(1'b1);
		idle(340);
		pulses(16);
		check(u_host.got, 16'h03C6);
	endtask : extra_clocks

	task automatic serial_frames();
		start_pin(1'b0);
		idle(10);
		pulses(1);
		idle(4);
		check(serial_mode, 1'b1);
		check(serial_data_oe, 1'b0);
		start_pin(1'b1);
		@(posedge ref_clk) sar_code <= 12'h5A3;
		start_pin(1'b0);
		idle(6);
		check({serial_data_oe, track_hold}, 2'b11);
		pulses(13);
		check(track_hold, 1'b1);
		pulses(1);
		idle(3);
		check(track_hold, 1'b0);
		pulses(2);
		idle(3);
		check(u_host.got, 16'h05A3);
		check(serial_data_oe, 1'b0);
		start_pin(1'b1);
		// two falls only: aborted, too early to power down
		start_pin(1'b0);
		pulses(2);
		start_pin(1'b1);
		idle(6);
		check({serial_data_oe, power_down}, 2'b00);
		start_pin(1'b0);
		pulses(6);
		start_pin(1'b1);
		idle(6);
		check(power_down, 1'b1);
		start_pin(1'b0);
		pulses(16);
		start_pin(1'b1);
		idle(6);
		check({power_down, serial_mode}, 2'b01);
		start_pin(1'b0);
		idle(10);
		start_pin(1'b1);
		idle(6);
		check(serial_mode, 1'b0);
	endtask : serial_frames

	// ======
	// main sequence and watchdog
	initial
	begin
		reset_n = 1'b0;
		sar_code = 12'h000;
		miscompares = 0;
		checks_done = 0;
		repeat (5) @(posedge ref_clk);
		reset_n <= 1'b1;
		idle(5);
		check({serial_mode, serial_data_oe, power_down}, 3'b000);
		read_int(12'hA5C, 1'b0);
		read_int(12'h7FF, 1'b1);
		extra_clocks();
		serial_frames();
		wrap_up();
	end

	initial
	begin
		repeat (20000) @(posedge ref_clk);
		miscompares++;
		wrap_up();
	end
endmodule : asr_readout_test

bind asr_readout asr_readout_asserts #(.CONV_CYCLES(CONV_CYCLES)) u_chk (
	.ref_clk(ref_clk), .reset_n(reset_n), .serial_clock(serial_clock),
	.convert_start_n(convert_start_n), .serial_data_out(serial_data_out),
	.serial_data_oe(serial_data_oe), .track_hold(track_hold),
	.power_down(power_down), .serial_mode(serial_mode),
	.conversion_busy(conversion_busy));
